// ---- rtl/phyc_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module phyc_ctrl #(
   parameter logic [1:0] MAC_SPD_DEFAULT = phyc_pkg::MAC_SPD_RST // Strap
) (
   input wire logic mclk_in,                   // Device clock
   input wire logic sys_rst_in,                // Synchronous reset, high
   input wire logic clk_en_in,                 // Freezes state when low
   input wire logic reg_wr_in,                 // Register write strobe
   input wire logic reg_rd_in,                 // Register read strobe
   input wire logic [4:0] reg_addr_in,         // Register number in page
   input wire logic [15:0] reg_wdata_in,       // Write data
   output logic [15:0] reg_rdata_out,          // Read data, next cycle
   input wire logic [2:0] media_mode_in,       // MAC-side media mode
   input wire logic mac_keepalive_in,          // Keep MAC side powered in power down
   input wire logic [3:0] adv_speed_in,        // Base speed advertisement
   input wire logic [1:0] adv_1000_in,         // 1000BASE-T advertisement
   input wire logic ser_in,                    // Serial transmit input
   input wire logic line_tx_in,                // Normal serial output data
   output logic ser_out,                       // Serial output data
   output logic link_enable_out,               // Link allowed up
   output logic soft_reset_out,                // State machines held
   output logic an_restart_out,                // Negotiation restart pulse
   output phyc_pkg::phyc_mode_s cu_mode_out,   // Active copper mode
   output logic fi_an_en_out,                  // Active fiber autoneg
   output logic fi_duplex_out,                 // Active fiber duplex
   output logic [1:0] mac_speed_out,           // Active MAC/loop speed
   output logic core_pwrdn_out,                // Core powered down
   output logic mac_pwrdn_out,                 // MAC side powered down
   output phyc_pkg::phyc_adv_s adv_out         // Advertisement to use
);
   typedef struct packed {
      logic [phyc_pkg::PAGE_W-1:0] page;
      phyc_pkg::phyc_mode_s cu_pend;
      phyc_pkg::phyc_mode_s cu_act;
      logic fi_anen_pend;
      logic fi_dup_pend;
      logic fi_anen_act;
      logic fi_dup_act;
      logic [1:0] mac_spd_pend;
      logic [1:0] mac_spd_act;
      logic loop;
      logic pd;
      logic mac_pd;
      logic an_restart;
      logic link_en;
      logic ser;
      logic [phyc_pkg::REG_DW-1:0] rdata;
   } phyc_ctrl_s;

   phyc_ctrl_s st_r;
   phyc_ctrl_s st_nxt;
   phyc_pkg::phyc_req_s req;
   logic srst_busy;
   logic srst_done;
   logic srst_start;
   logic wr_ctrl;
   logic rst_req;
   logic pd_fall;
   logic restart_req;
   logic apply;

   // Control register exists on the first three pages only
   function automatic logic is_ctrl(input logic [4:0] addr,
                                    input logic [7:0] page);
      is_ctrl = (addr == phyc_pkg::REG_CTRL) && (page <= phyc_pkg::PAGE_MAC);
   endfunction

   function automatic logic [1:0] fiber_speed(input logic [2:0] mode);
      fiber_speed = (mode == phyc_pkg::MEDIA_FX) ? phyc_pkg::SPD_100 :
                    phyc_pkg::SPD_1000;
   endfunction

   function automatic logic [15:0] ctrl_word(input phyc_ctrl_s s,
                                             input logic busy,
                                             input logic [2:0] mode);
      logic [15:0] w;
      logic [1:0] fs;
      w = '0;
      fs = fiber_speed(mode);
      // Reset bit reads busy, zero in normal operation
      w[phyc_pkg::B_RST] = busy;
      w[phyc_pkg::B_PD] = s.pd;
      // Isolate and collision test stay zero; low bits zero
      case (s.page)
         phyc_pkg::PAGE_COPPER: begin
            w[phyc_pkg::B_LOOP] = s.loop;
            // Pending values read back at once
            w[phyc_pkg::B_SPD_MSB] = s.cu_pend.speed[1];
            w[phyc_pkg::B_SPD_LSB] = s.cu_pend.speed[0];
            w[phyc_pkg::B_ANEN] = s.cu_pend.an_en;
            w[phyc_pkg::B_DUP] = s.cu_pend.duplex;
         end
         phyc_pkg::PAGE_FIBER: begin
            w[phyc_pkg::B_LOOP] = s.loop;
            w[phyc_pkg::B_SPD_MSB] = fs[1];
            w[phyc_pkg::B_SPD_LSB] = fs[0];
            w[phyc_pkg::B_ANEN] = s.fi_anen_pend &&
                                  (mode != phyc_pkg::MEDIA_FX);
            w[phyc_pkg::B_DUP] = s.fi_dup_pend;
         end
         phyc_pkg::PAGE_MAC: begin
            w[phyc_pkg::B_SPD_MSB] = s.mac_spd_pend[1];
            w[phyc_pkg::B_SPD_LSB] = s.mac_spd_pend[0];
         end
         default: begin
            w = '0;
         end
      endcase
      ctrl_word = w;
   endfunction

   assign req = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in,
                  wdata: reg_wdata_in};

   always_comb begin
      st_nxt = st_r;
      // Access decoded within the selected page
      wr_ctrl = req.wr && is_ctrl(req.addr, st_r.page);
      // Reset reachable through any of the three pages
      rst_req = wr_ctrl && req.wdata[phyc_pkg::B_RST];
      // Power-down exit forces reset and restart
      pd_fall = wr_ctrl && st_r.pd && !req.wdata[phyc_pkg::B_PD];
      // Restart acts on the write itself
      restart_req = wr_ctrl && req.wdata[phyc_pkg::B_RESTART] &&
                    (st_r.page != phyc_pkg::PAGE_MAC);
      srst_start = rst_req || pd_fall;
      // Deferred fields take effect only here
      apply = srst_start || restart_req;
      // Page register reachable on every page
      if (req.wr && req.addr == phyc_pkg::REG_PAGE) begin
         st_nxt.page = req.wdata[phyc_pkg::PAGE_W-1:0];
      end
      if (wr_ctrl) begin
         // Power-down bit shared by all three pages
         st_nxt.pd = req.wdata[phyc_pkg::B_PD];
         case (st_r.page)
            phyc_pkg::PAGE_COPPER: begin
               // Loopback shared with the fiber page
               st_nxt.loop = req.wdata[phyc_pkg::B_LOOP];
               // Speed is {bit 6, bit 13}
               st_nxt.cu_pend.speed = {req.wdata[phyc_pkg::B_SPD_MSB],
                                       req.wdata[phyc_pkg::B_SPD_LSB]};
               st_nxt.cu_pend.an_en = req.wdata[phyc_pkg::B_ANEN];
               st_nxt.cu_pend.duplex = req.wdata[phyc_pkg::B_DUP];
            end
            phyc_pkg::PAGE_FIBER: begin
               st_nxt.loop = req.wdata[phyc_pkg::B_LOOP];
               st_nxt.fi_anen_pend = req.wdata[phyc_pkg::B_ANEN];
               st_nxt.fi_dup_pend = req.wdata[phyc_pkg::B_DUP];
            end
            default: begin
               // MAC-side speed set here, fiber bits are fixed
               st_nxt.mac_spd_pend = {req.wdata[phyc_pkg::B_SPD_MSB],
                                      req.wdata[phyc_pkg::B_SPD_LSB]};
            end
         endcase
      end
      // Same-cycle write and trigger applies the new value
      if (apply) begin
         st_nxt.cu_act = st_nxt.cu_pend;
         st_nxt.fi_anen_act = st_nxt.fi_anen_pend &&
                              (media_mode_in != phyc_pkg::MEDIA_FX);
         st_nxt.fi_dup_act = st_nxt.fi_dup_pend;
         st_nxt.mac_spd_act = st_nxt.mac_spd_pend;
      end
      // Restart after any reset or a restart write
      st_nxt.an_restart = restart_req || srst_done;
      st_nxt.mac_pd = st_nxt.pd && !mac_keepalive_in;
      // Loopback turns input around and holds the link down
      st_nxt.ser = st_nxt.loop ? ser_in : line_tx_in;
      st_nxt.link_en = !st_nxt.loop && !st_nxt.pd && !srst_busy;
      if (req.rd) begin
         if (req.addr == phyc_pkg::REG_PAGE) begin
            st_nxt.rdata = {{(phyc_pkg::REG_DW-phyc_pkg::PAGE_W){1'b0}},
                            st_r.page};
         end else if (is_ctrl(req.addr, st_r.page)) begin
            st_nxt.rdata = ctrl_word(st_r, srst_busy, media_mode_in);
            st_nxt.rdata[phyc_pkg::B_RESTART] = st_r.an_restart &&
                                     (st_r.page != phyc_pkg::PAGE_MAC);
         end else begin
            st_nxt.rdata = '0;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         st_r <= '0;
         st_r.cu_pend <= '{an_en: phyc_pkg::CU_ANEN_RST,
                           speed: phyc_pkg::CU_SPD_RST,
                           duplex: phyc_pkg::CU_DUP_RST};
         st_r.cu_act <= '{an_en: phyc_pkg::CU_ANEN_RST,
                          speed: phyc_pkg::CU_SPD_RST,
                          duplex: phyc_pkg::CU_DUP_RST};
         st_r.fi_anen_pend <= phyc_pkg::FI_ANEN_RST;
         st_r.fi_dup_pend <= phyc_pkg::FI_DUP_RST;
         st_r.fi_anen_act <= phyc_pkg::FI_ANEN_RST;
         st_r.fi_dup_act <= phyc_pkg::FI_DUP_RST;
         st_r.mac_spd_pend <= MAC_SPD_DEFAULT;
         st_r.mac_spd_act <= MAC_SPD_DEFAULT;
         // Negotiation restarts right after a hardware reset
         st_r.an_restart <= 1'b1;
      end else if (clk_en_in) begin
         st_r <= st_nxt;
      end
   end

   phyc_srst_seq u_srst (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .clk_en_in(clk_en_in),
      .start_in(srst_start),
      .busy_out(srst_busy),
      .done_out(srst_done)
   );

   phyc_adv u_adv (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .clk_en_in(clk_en_in),
      .mode_in(st_r.cu_act),
      .adv_speed_in(adv_speed_in),
      .adv_1000_in(adv_1000_in),
      .adv_out(adv_out)
   );

   assign reg_rdata_out = st_r.rdata;
   assign ser_out = st_r.ser;
   assign link_enable_out = st_r.link_en;
   assign soft_reset_out = srst_busy;
   assign an_restart_out = st_r.an_restart;
   assign cu_mode_out = st_r.cu_act;
   assign fi_an_en_out = st_r.fi_anen_act;
   assign fi_duplex_out = st_r.fi_dup_act;
   assign mac_speed_out = st_r.mac_spd_act;
   assign core_pwrdn_out = st_r.pd;
   assign mac_pwrdn_out = st_r.mac_pd;

   chk_srst_any_page: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (clk_en_in && wr_ctrl && req.wdata[phyc_pkg::B_RST])
      |=> soft_reset_out && (an_restart_out == $past(restart_req)))
      else $error("reset write did not start soft reset");
   chk_loop_route: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (clk_en_in && st_nxt.loop) |=> ser_out == $past(ser_in)
      && !link_enable_out)
      else $error("loopback data or link drop wrong");
   chk_update_defer: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (clk_en_in && wr_ctrl && !apply) |=> $stable(cu_mode_out)
      && $stable(mac_speed_out))
      else $error("deferred field took effect early");
   chk_pd_exit: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (clk_en_in && pd_fall) |=> soft_reset_out ##[1:25] an_restart_out)
      else $error("power-down exit did not reset and restart");
   chk_mac_pwrdn: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      clk_en_in |=> mac_pwrdn_out ==
      (core_pwrdn_out && !$past(mac_keepalive_in)))
      else $error("MAC side power down wrong");
   chk_rsvd_zero: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (clk_en_in && req.rd && is_ctrl(req.addr, st_r.page))
      |=> reg_rdata_out[phyc_pkg::RSVD_W-1:0] == '0
      && !reg_rdata_out[phyc_pkg::B_ISO] && !reg_rdata_out[phyc_pkg::B_COL])
      else $error("reserved or no-effect bits not zero");
   chk_fiber_speed: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (clk_en_in && req.rd && req.addr == phyc_pkg::REG_CTRL
      && st_r.page == phyc_pkg::PAGE_FIBER)
      |=> {reg_rdata_out[phyc_pkg::B_SPD_MSB],
      reg_rdata_out[phyc_pkg::B_SPD_LSB]} ==
      fiber_speed($past(media_mode_in)))
      else $error("fiber speed bits wrong");
   chk_page_read: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (clk_en_in && req.wr && req.addr == phyc_pkg::REG_PAGE) ##1
      (clk_en_in && req.rd && req.addr == phyc_pkg::REG_PAGE && !req.wr)
      |=> reg_rdata_out[phyc_pkg::PAGE_W-1:0] ==
      $past(reg_wdata_in[phyc_pkg::PAGE_W-1:0], 2))
      else $error("page register read back wrong");
   chk_restart_once: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (clk_en_in && an_restart_out && !restart_req && !srst_done)
      |=> !an_restart_out)
      else $error("restart pulse did not clear itself");
   chk_hw_restart: assert property (@(posedge mclk_in)
      $fell(sys_rst_in) |-> an_restart_out)
      else $error("no negotiation restart after hardware reset");
   chk_pd_link: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (clk_en_in && st_nxt.pd) |=> core_pwrdn_out && !link_enable_out)
      else $error("power down did not hold the link off");
   chk_unmapped_zero: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (clk_en_in && req.rd && req.addr != phyc_pkg::REG_PAGE
      && !is_ctrl(req.addr, st_r.page)) |=> reg_rdata_out == '0)
      else $error("unmapped register did not read zero");
endmodule
`default_nettype wire

// ---- rtl/phyc_pkg.sv ----
`default_nettype none
package phyc_pkg;
   localparam int REG_AW = 5;
   localparam int REG_DW = 16;
   localparam int PAGE_W = 8;
   localparam logic [REG_AW-1:0] REG_CTRL = 5'h00;
   localparam logic [REG_AW-1:0] REG_PAGE = 5'h16;
   localparam logic [PAGE_W-1:0] PAGE_COPPER = 8'h00;
   localparam logic [PAGE_W-1:0] PAGE_FIBER = 8'h01;
   localparam logic [PAGE_W-1:0] PAGE_MAC = 8'h02;
   // Bit positions inside the control register of each page
   localparam int B_RST = 15;
   localparam int B_LOOP = 14;
   localparam int B_SPD_LSB = 13;
   localparam int B_ANEN = 12;
   localparam int B_PD = 11;
   localparam int B_ISO = 10;
   localparam int B_RESTART = 9;
   localparam int B_DUP = 8;
   localparam int B_COL = 7;
   localparam int B_SPD_MSB = 6;
   localparam int RSVD_W = 6;
   // Speed codes as {msb, lsb}
   localparam logic [1:0] SPD_10 = 2'h0;
   localparam logic [1:0] SPD_100 = 2'h1;
   localparam logic [1:0] SPD_1000 = 2'h2;
   localparam logic [1:0] SPD_RSVD = 2'h3;
   localparam logic [2:0] MEDIA_FX = 3'h0;
   // Reset values
   localparam logic [1:0] CU_SPD_RST = SPD_1000;
   localparam logic CU_ANEN_RST = 1'b1;
   localparam logic CU_DUP_RST = 1'b1;
   localparam logic FI_ANEN_RST = 1'b1;
   localparam logic FI_DUP_RST = 1'b1;
   localparam logic [1:0] MAC_SPD_RST = SPD_1000;
   // Soft reset duration
   localparam int SRST_TIME_NS = 100;
   localparam int CLK_PERIOD_NS = 5;
   localparam int SRST_CNT_W = 5;
   localparam logic [SRST_CNT_W-1:0] SRST_CYCLES =
      SRST_CNT_W'((SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [SRST_CNT_W-1:0] SRST_CNT_ONE = 5'h01;
   typedef struct packed {
      logic an_en;
      logic [1:0] speed;
      logic duplex;
   } phyc_mode_s;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [REG_AW-1:0] addr;
      logic [REG_DW-1:0] wdata;
   } phyc_req_s;
   typedef struct packed {
      logic an_run;
      logic [3:0] speed_adv;
      logic adv_1000fd;
      logic adv_1000hd;
   } phyc_adv_s;
endpackage
`default_nettype wire

// ---- rtl/phyc_srst_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
module phyc_srst_seq (
   input wire logic mclk_in,   // Device clock
   input wire logic sys_rst_in, // Synchronous reset, high
   input wire logic clk_en_in, // Freezes state when low
   input wire logic start_in,  // Begin or extend soft reset
   output logic busy_out,      // Soft reset in progress
   output logic done_out       // One cycle when reset ends
);
   typedef enum logic {PHYC_IDLE, PHYC_RUN} phyc_seq_e;
   typedef struct packed {
      phyc_seq_e state;
      logic [phyc_pkg::SRST_CNT_W-1:0] cnt;
      logic busy;
      logic done;
   } phyc_seq_s;
   phyc_seq_s st_r;
   phyc_seq_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      case (st_r.state)
         PHYC_IDLE: begin
            if (start_in) begin
               st_nxt.state = PHYC_RUN;
               st_nxt.cnt = phyc_pkg::SRST_CYCLES;
               st_nxt.busy = 1'b1;
            end
         end
         PHYC_RUN: begin
            if (start_in) begin
               st_nxt.cnt = phyc_pkg::SRST_CYCLES;
            end else if (st_r.cnt == phyc_pkg::SRST_CNT_ONE) begin
               st_nxt.state = PHYC_IDLE;
               st_nxt.busy = 1'b0;
               st_nxt.done = 1'b1;
            end else begin
               st_nxt.cnt = st_r.cnt - phyc_pkg::SRST_CNT_ONE;
            end
         end
         default: begin
            st_nxt.state = PHYC_IDLE;
            st_nxt.busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         st_r <= '0;
      end else if (clk_en_in) begin
         st_r <= st_nxt;
      end
   end

   assign busy_out = st_r.busy;
   assign done_out = st_r.done;

   chk_srst_self_clear: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (clk_en_in && start_in) |=> busy_out ##[1:25] !busy_out)
      else $error("soft reset did not clear itself");
endmodule
`default_nettype wire

// ---- rtl/phyc_adv.sv ----
`timescale 1ns/1ps
`default_nettype none
module phyc_adv (
   input wire logic mclk_in,                 // Device clock
   input wire logic sys_rst_in,              // Synchronous reset, high
   input wire logic clk_en_in,               // Freezes state when low
   input wire phyc_pkg::phyc_mode_s mode_in, // Active copper mode
   input wire logic [3:0] adv_speed_in,      // Base speed advertisement
   input wire logic [1:0] adv_1000_in,       // 1000BASE-T fd, hd
   output phyc_pkg::phyc_adv_s adv_out       // Advertisement to use
);
   phyc_pkg::phyc_adv_s st_r;
   phyc_pkg::phyc_adv_s st_nxt;
   logic forced_1000;

   always_comb begin
      forced_1000 = !mode_in.an_en && (mode_in.speed == phyc_pkg::SPD_1000);
      st_nxt.an_run = mode_in.an_en;
      st_nxt.speed_adv = adv_speed_in;
      st_nxt.adv_1000fd = adv_1000_in[1];
      st_nxt.adv_1000hd = adv_1000_in[0];
      if (forced_1000) begin
         st_nxt.an_run = 1'b1;
         st_nxt.adv_1000fd = mode_in.duplex;
         st_nxt.adv_1000hd = !mode_in.duplex;
         st_nxt.speed_adv = 4'h0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         st_r <= '0;
      end else if (clk_en_in) begin
         st_r <= st_nxt;
      end
   end

   assign adv_out = st_r;

   chk_forced_adv: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (clk_en_in && !mode_in.an_en && mode_in.speed == phyc_pkg::SPD_1000)
      |=> adv_out.an_run && (adv_out.adv_1000fd == $past(mode_in.duplex))
      && (adv_out.adv_1000hd != adv_out.adv_1000fd))
      else $error("forced 1000 advertisement wrong");
   chk_adv_ignored: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (clk_en_in && !mode_in.an_en && mode_in.speed == phyc_pkg::SPD_1000
      && adv_speed_in != 4'h0) |=> adv_out.speed_adv == 4'h0)
      else $error("speed fields not ignored in forced 1000");
endmodule
`default_nettype wire

// ---- test/phyc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module phyc_host (
   input wire logic mclk_in,      // Device clock
   output logic wr_out,           // Write strobe
   output logic rd_out,           // Read strobe
   output logic [4:0] addr_out,   // Register number
   output logic [15:0] wdata_out  // Write data
);
   initial begin
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = 5'h00;
      wdata_out = 16'h0000;
   end
   // Held over one taken edge; released lines flip so stale data shows
   task automatic xfer(input logic w, input logic [4:0] a,
                       input logic [15:0] d);
      @(negedge mclk_in);
      wr_out = w;
      rd_out = !w;
      addr_out = a;
      wdata_out = d;
      @(negedge mclk_in);
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = ~a;
      wdata_out = ~d;
   endtask
   task automatic page(input logic [7:0] p);
      xfer(1'b1, 5'h16, {8'h00, p});
   endtask
   // Page write, then its read-back on the very next edge
   task automatic page_rd(input logic [7:0] p);
      @(negedge mclk_in);
      wr_out = 1'b1;
      addr_out = 5'h16;
      wdata_out = {8'h00, p};
      @(negedge mclk_in);
      wr_out = 1'b0;
      rd_out = 1'b1;
      @(negedge mclk_in);
      rd_out = 1'b0;
      addr_out = ~addr_out;
      wdata_out = ~wdata_out;
   endtask
endmodule
`default_nettype wire

// ---- test/tb_phyc_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_phyc_ctrl;
   logic mclk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic reg_wr, reg_rd, rd_q, sp, ser_in = 1'b0, line_tx_in = 1'b0;
   logic mac_keepalive_in = 1'b1;
   logic clk_en = 1'b1, fi_an_en_out, fi_duplex_out;
   logic [3:0] adv_spd = 4'h1;
   logic [1:0] adv_1000 = 2'h0;
   logic link_enable_out, soft_reset_out, an_restart_out, ser_out;
   logic core_pwrdn_out, mac_pwrdn_out;
   logic [1:0] mac_speed_out;
   logic [2:0] media_mode_in = 3'h0;
   logic [4:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata_out, exp_q[$];
   logic [31:0] rs = 32'h000182e8;
   phyc_pkg::phyc_mode_s cu_mode_out;
   phyc_pkg::phyc_adv_s adv_out;
   int error_cnt = 0;
   int samples_checked = 0;
   int n;
   always #2.5 mclk_in = ~mclk_in;
   phyc_host u_host (.mclk_in(mclk_in), .wr_out(reg_wr), .rd_out(reg_rd),
      .addr_out(reg_addr), .wdata_out(reg_wdata));
   phyc_ctrl uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
      .clk_en_in(clk_en), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
      .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
      .reg_rdata_out(reg_rdata_out), .media_mode_in(media_mode_in),
      .mac_keepalive_in(mac_keepalive_in), .adv_speed_in(adv_spd),
      .adv_1000_in(adv_1000), .ser_in(ser_in), .line_tx_in(line_tx_in),
      .ser_out(ser_out), .link_enable_out(link_enable_out),
      .soft_reset_out(soft_reset_out), .an_restart_out(an_restart_out),
      .cu_mode_out(cu_mode_out), .fi_an_en_out(fi_an_en_out),
      .fi_duplex_out(fi_duplex_out),
      .mac_speed_out(mac_speed_out), .core_pwrdn_out(core_pwrdn_out),
      .mac_pwrdn_out(mac_pwrdn_out), .adv_out(adv_out));
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Read data shows on the edge that takes the read
   always @(posedge mclk_in) rd_q <= reg_rd;
   always @(negedge mclk_in) begin
      if (rd_q === 1'b1)
         cmp(reg_rdata_out, exp_q.pop_front());
   end
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      u_host.xfer(1'b0, a, 16'h0000);
   endtask
   task automatic wr(input logic [15:0] d);
      u_host.xfer(1'b1, 5'h00, d);
   endtask
   task automatic waitsr();
      for (n = 0; n < 40 && soft_reset_out === 1'b1; n++)
         @(negedge mclk_in);
      if (n == 40) begin
         error_cnt++;
         report_and_stop();
      end
   endtask
   task automatic lp(input logic on);
      for (int i = 0; i < 8; i++) begin
         rs = xs(rs);
         ser_in = rs[0];
         line_tx_in = rs[1];
         sp = on ? ser_in : line_tx_in;
         @(negedge mclk_in);
         cmp({15'h0, ser_out}, {15'h0, sp});
         cmp({15'h0, link_enable_out}, {15'h0, !on});
      end
   endtask
   initial begin
      rs = xs(rs);
      adv_spd = rs[3:0] | 4'h1;
      adv_1000 = rs[5:4];
      repeat (5) @(negedge mclk_in);
      sys_rst_in = 1'b0;
      repeat (4) @(negedge mclk_in);
      rd(5'h00, 16'h1140);
      cmp({9'h000, adv_out}, {9'h000, 1'b1, adv_spd, adv_1000});
      $display("reset values done");
      exp_q.push_back(16'h0001);
      u_host.page_rd(8'h01);
      rd(5'h00, 16'h2100);
      media_mode_in = 3'h5;
      rd(5'h00, 16'h1140);
      wr(16'h0000);
      cmp({14'h0, fi_an_en_out, fi_duplex_out}, 16'h0003);
      u_host.page(8'h03);
      rd(5'h00, 16'h0000);
      $display("paging done");
      u_host.page(8'h00);
      wr(16'h24bf);
      rd(5'h00, 16'h2000);
      cmp({12'h000, cu_mode_out}, 16'h000d);
      wr(16'h2200);
      cmp({15'h0, an_restart_out}, 16'h0001);
      cmp({12'h000, cu_mode_out}, 16'h0002);
      cmp({14'h0, fi_an_en_out, fi_duplex_out}, 16'h0000);
      $display("deferred update done");
      wr(16'h0140);
      wr(16'h0340);
      @(negedge mclk_in);
      cmp({9'h000, adv_out}, 16'h0042);
      wr(16'h0240);
      @(negedge mclk_in);
      cmp({9'h000, adv_out}, 16'h0041);
      $display("forced 1000 done");
      u_host.page(8'h02);
      wr(16'ha000);
      cmp({15'h0, soft_reset_out}, 16'h0001);
      rd(5'h00, 16'ha000);
      waitsr();
      cmp(n[15:0], 16'(phyc_pkg::SRST_CYCLES - 2));
      @(negedge mclk_in);
      cmp({15'h0, an_restart_out}, 16'h0001);
      cmp({14'h0, mac_speed_out}, 16'h0001);
      $display("soft reset done");
      u_host.page(8'h00);
      wr(16'h4140);
      @(negedge mclk_in);
      lp(1'b1);
      wr(16'h0140);
      @(negedge mclk_in);
      lp(1'b0);
      $display("loopback done");
      clk_en = 1'b0;
      wr(16'h0940);
      cmp({14'h0, core_pwrdn_out, mac_pwrdn_out}, 16'h0000);
      clk_en = 1'b1;
      wr(16'h0940);
      cmp({14'h0, core_pwrdn_out, mac_pwrdn_out}, 16'h0002);
      mac_keepalive_in = 1'b0;
      repeat (2) @(negedge mclk_in);
      cmp({14'h0, core_pwrdn_out, mac_pwrdn_out}, 16'h0003);
      wr(16'h0140);
      cmp({15'h0, soft_reset_out}, 16'h0001);
      waitsr();
      $display("power down done");
      sys_rst_in = 1'b1;
      repeat (2) @(negedge mclk_in);
      sys_rst_in = 1'b0;
      cmp({15'h0, an_restart_out}, 16'h0001);
      rd(5'h00, 16'h1140);
      $display("mid-run reset done");
      report_and_stop();
   end
endmodule
`default_nettype wire
